/* File: design/oar_defs.svh */
// Constants for the octal converter convert-and-readout block.
// Assumes it is included by bare name from the package and the design module.
`ifndef OAR_DEFS_SVH
`define OAR_DEFS_SVH

`define OAR_NUM_CH 8
`define OAR_NUM_LANES 4
`define OAR_CH_PER_LANE 2
`define OAR_RES_BITS 13
`define OAR_MSB_POS 4'hC
`define OAR_CMOS_SLOT 8'h0D
`define OAR_LVDS_SLOT 8'h10
`define OAR_CMOS_PERIOD 8'h68
`define OAR_LVDS_PERIOD 8'h80
`define OAR_CNT_W 8
`define OAR_CONV_CNT_W 16
`define OAR_T_CONV_NS 450
`define OAR_CLK_PERIOD_NS 25
`define OAR_CONV_CYCLES ((`OAR_T_CONV_NS) / (`OAR_CLK_PERIOD_NS))
`define OAR_IO_CMOS 2'h0
`define OAR_IO_LVDS 2'h1
`define OAR_IO_LVDS_LP 2'h2

`endif

/* File: design/oar_pkg.sv */
// Types shared by the readout block and its bench.
// Assumes oar_defs.svh is on the include path.
`include "oar_defs.svh"

package oar_pkg;

  typedef logic [`OAR_RES_BITS-1:0] oar_word_t;

  typedef struct packed {
    oar_word_t [`OAR_NUM_CH-1:0] ch;
  } oar_samples_t;

  typedef struct packed {
    logic ddr;
    logic lvds;
    logic low_power;
  } oar_mode_t;

  typedef enum logic [2:0] {
    oar_st_acquire = 3'h1,
    oar_st_convert = 3'h2,
    oar_st_readout = 3'h4
  } oar_state_t;

endpackage : oar_pkg

/* File: design/oar_readout.sv */
// Convert-and-readout logic of the eight-channel sampling converter.
// Assumes a 40 MHz system clock, a host-driven shift clock that idles while the
// convert strobe is high, and converter-core codes on sample_in in the clock domain.
`include "oar_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module oar_readout #(
  parameter int unsigned CONV_CYCLES = `OAR_CONV_CYCLES
) (
  // System clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Converter core codes
  input wire oar_pkg::oar_samples_t sample_in,
  // Mode straps
  input wire logic data_rate_select,
  input wire logic [1:0] io_mode_select,
  // Host link
  input wire logic shift_clock,
  input wire logic convert_strobe_n,
  output logic echo_clock_out,
  // CMOS data outputs
  output logic serial_out_ch1,
  output logic serial_out_ch2,
  output logic serial_out_ch3,
  output logic serial_out_ch4,
  output logic serial_out_ch5,
  output logic serial_out_ch6,
  output logic serial_out_ch7,
  output logic serial_out_ch8,
  output logic serial_out_en,
  // LVDS data lanes
  output logic diff_lane_a_p,
  output logic diff_lane_a_n,
  output logic diff_lane_b_p,
  output logic diff_lane_b_n,
  output logic diff_lane_c_p,
  output logic diff_lane_c_n,
  output logic diff_lane_d_p,
  output logic diff_lane_d_n,
  output logic diff_lane_en,
  // Status
  output logic converting,
  output logic result_ready,
  output oar_pkg::oar_mode_t active_mode
);

  localparam int unsigned CW = `OAR_CNT_W;
  localparam int unsigned CONV_W = `OAR_CONV_CNT_W;

  // System domain state.
  logic cnv_meta_reg;
  logic cnv_sync_reg;
  logic cnv_prev_reg;
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_sync_reg;
  oar_pkg::oar_state_t state_reg;
  oar_pkg::oar_state_t state_next;
  logic [CONV_W-1:0] conv_cnt_reg;
  oar_pkg::oar_samples_t result_reg;
  oar_pkg::oar_mode_t mode_reg;
  oar_pkg::oar_mode_t mode_next;
  logic converting_reg;
  logic ready_reg;
  logic cmos_en_reg;
  logic lvds_en_reg;
  logic cnv_fall;

  // Mode and result words change only while the host keeps the shift clock still,
  // so the link side reads them without a synchroniser of its own.
  // Link domain state.
  logic [CW-1:0] fall_cnt_reg;
  logic [CW-1:0] rise_cnt_reg;
  logic echo_rise_reg;
  logic echo_fall_reg;
  logic [CW-1:0] period;
  logic [CW-1:0] slot;
  logic [CW:0] edge_sum;
  logic [CW-1:0] stream_pos;
  logic [CW-1:0] word_idx;
  logic [CW-1:0] bit_idx;
  logic [`OAR_NUM_CH-1:0] cmos_bit;
  logic [`OAR_NUM_LANES-1:0] lane_bit;

  // Advances an edge counter and wraps it at the end of the channel stream.
  function automatic logic [CW-1:0] oar_step(input logic [CW-1:0] cnt, input logic [CW-1:0] per);
    logic [CW-1:0] nxt;
    nxt = CW'(cnt + 1'b1);
    oar_step = (nxt == per) ? '0 : nxt;
  endfunction : oar_step

  // strobe independent of mode
  // Two flops settle the asynchronous strobe before any system-domain logic reads it.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnv_meta_reg <= 1'b1;
      cnv_sync_reg <= 1'b1;
    end else begin
      cnv_meta_reg <= convert_strobe_n;
      cnv_sync_reg <= cnv_meta_reg;
    end
  end

  // The history flop turns the settled strobe into a one-cycle fall pulse.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnv_prev_reg <= 1'b1;
    end else begin
      cnv_prev_reg <= cnv_sync_reg;
    end
  end

  assign cnv_fall = cnv_prev_reg & ~cnv_sync_reg;

  // Straps are static pins but still pass two flip-flops before use.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      strap_meta_reg <= 3'h0;
      strap_sync_reg <= 3'h0;
    end else begin
      strap_meta_reg <= {data_rate_select, io_mode_select};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  always_comb begin
    mode_next.ddr = strap_sync_reg[2];
    mode_next.lvds = (strap_sync_reg[1:0] != `OAR_IO_CMOS);
    mode_next.low_power = (strap_sync_reg[1:0] == `OAR_IO_LVDS_LP);
  end

  // The mode is frozen for a whole frame so the link side sees a steady word.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mode_reg <= '0;
    end else if (cnv_fall) begin
      mode_reg <= mode_next;
    end
  end

  // A strobe that returns high before the result is ready abandons the frame.
  // There is no error flag; the next fall simply starts a fresh conversion.
  // conversion sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      oar_pkg::oar_st_acquire: begin
        if (cnv_fall) begin
          state_next = oar_pkg::oar_st_convert;
        end
      end
      oar_pkg::oar_st_convert: begin
        if (cnv_sync_reg) begin
          state_next = oar_pkg::oar_st_acquire;
        end else if (conv_cnt_reg == CONV_W'(CONV_CYCLES - 1)) begin
          state_next = oar_pkg::oar_st_readout;
        end
      end
      oar_pkg::oar_st_readout: begin
        if (cnv_sync_reg) begin
          state_next = oar_pkg::oar_st_acquire;
        end
      end
      default: begin
        state_next = oar_pkg::oar_st_acquire;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= oar_pkg::oar_st_acquire;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      conv_cnt_reg <= '0;
    end else if (state_reg == oar_pkg::oar_st_convert) begin
      conv_cnt_reg <= CONV_W'(conv_cnt_reg + 1'b1);
    end else begin
      conv_cnt_reg <= '0;
    end
  end

  // The code read out is the last one tracked before the settled strobe falls,
  // which is two clocks after the pin itself falls.
  // track while strobe high
  always_ff @(posedge clock) begin
    if (!resetn) begin
      result_reg <= '0;
    end else if (state_reg == oar_pkg::oar_st_acquire && cnv_sync_reg) begin
      result_reg <= sample_in;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      converting_reg <= 1'b0;
    end else begin
      converting_reg <= (state_next == oar_pkg::oar_st_convert);
    end
  end

  // result ready flag
  // Both flags follow the next state so they change on the same edge as the state.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == oar_pkg::oar_st_readout);
    end
  end

  // Outputs are released on the third clock after the strobe returns high, one frame at a time.
  // single-ended drive enable
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cmos_en_reg <= 1'b0;
    end else begin
      cmos_en_reg <= ~cnv_sync_reg & (state_reg != oar_pkg::oar_st_acquire) & ~mode_reg.lvds;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      lvds_en_reg <= 1'b0;
    end else begin
      lvds_en_reg <= ~cnv_sync_reg & (state_reg != oar_pkg::oar_st_acquire) & mode_reg.lvds;
    end
  end

  // Lane slots are sixteen edges wide so that two codes fill a 32-edge lane read;
  // the price is three idle pad bits after every lane code.
  assign period = mode_reg.lvds ? `OAR_LVDS_PERIOD : `OAR_CMOS_PERIOD;
  assign slot = mode_reg.lvds ? `OAR_LVDS_SLOT : `OAR_CMOS_SLOT;

  // The shift clock may stop between frames, so the frame's own strobe clears
  // the link counters instead of any clocked reset.
  // falling edges advance
  always_ff @(negedge shift_clock or posedge convert_strobe_n) begin
    if (convert_strobe_n) begin
      fall_cnt_reg <= '0;
    end else begin
      fall_cnt_reg <= oar_step(fall_cnt_reg, period);
    end
  end

  always_ff @(posedge shift_clock or posedge convert_strobe_n) begin
    if (convert_strobe_n) begin
      rise_cnt_reg <= '0;
    end else begin
      rise_cnt_reg <= oar_step(rise_cnt_reg, period);
    end
  end

  // The echo comes from a flop on each shift clock edge, so it carries the same
  // clock-to-output delay as the data and stays skew-matched to it.
  // echo clock pair
  always_ff @(posedge shift_clock or posedge convert_strobe_n) begin
    if (convert_strobe_n) begin
      echo_rise_reg <= 1'b0;
    end else begin
      echo_rise_reg <= ~echo_fall_reg;
    end
  end

  always_ff @(negedge shift_clock or posedge convert_strobe_n) begin
    if (convert_strobe_n) begin
      echo_fall_reg <= 1'b0;
    end else begin
      echo_fall_reg <= echo_rise_reg;
    end
  end

  assign echo_clock_out = echo_rise_reg ^ echo_fall_reg;

  // One flop cannot clock on both edges, so each edge keeps its own counter and
  // in double-rate mode their sum, folded once at the stream length, is the stream position; single rate uses the falling count alone.
  // sum both edge counts
  assign edge_sum = {1'b0, fall_cnt_reg} + (mode_reg.ddr ? {1'b0, rise_cnt_reg} : {(CW+1){1'b0}});
  assign stream_pos = (edge_sum >= {1'b0, period}) ? CW'(edge_sum - {1'b0, period}) : CW'(edge_sum);
  assign word_idx = CW'(stream_pos / slot);
  assign bit_idx = CW'(stream_pos % slot);

  genvar gi;
  generate
    for (gi = 0; gi < `OAR_NUM_CH; gi++) begin : g_cmos
      logic [2:0] ch_sel;
      logic [3:0] pos;
      assign ch_sel = 3'(gi + word_idx);
      assign pos = 4'(`OAR_MSB_POS - bit_idx[3:0]);
      assign cmos_bit[gi] = result_reg.ch[ch_sel][pos];
    end
    for (gi = 0; gi < `OAR_NUM_LANES; gi++) begin : g_lane
      logic [2:0] ch_sel;
      logic [3:0] pos;
      assign ch_sel = 3'(gi * `OAR_CH_PER_LANE + word_idx);
      assign pos = 4'(`OAR_MSB_POS - bit_idx[3:0]);
      // Slot bits past the 13-bit code read as zero padding.
      assign lane_bit[gi] = (bit_idx < CW'(`OAR_RES_BITS)) ? result_reg.ch[ch_sel][pos] : 1'b0;
    end
  endgenerate

  assign serial_out_ch1 = cmos_bit[0];
  assign serial_out_ch2 = cmos_bit[1];
  assign serial_out_ch3 = cmos_bit[2];
  assign serial_out_ch4 = cmos_bit[3];
  assign serial_out_ch5 = cmos_bit[4];
  assign serial_out_ch6 = cmos_bit[5];
  assign serial_out_ch7 = cmos_bit[6];
  assign serial_out_ch8 = cmos_bit[7];
  assign serial_out_en = cmos_en_reg;

  assign diff_lane_a_p = lane_bit[0];
  assign diff_lane_a_n = ~lane_bit[0];
  assign diff_lane_b_p = lane_bit[1];
  assign diff_lane_b_n = ~lane_bit[1];
  assign diff_lane_c_p = lane_bit[2];
  assign diff_lane_c_n = ~lane_bit[2];
  assign diff_lane_d_p = lane_bit[3];
  assign diff_lane_d_n = ~lane_bit[3];
  assign diff_lane_en = lvds_en_reg;

  assign converting = converting_reg;
  assign result_ready = ready_reg;
  assign active_mode = mode_reg;

endmodule : oar_readout

`default_nettype wire

/* File: bench/oar_readout_props.sv */
// Checker for strobe, conversion and output-enable timing of the readout block.
// Assumes it is bound to oar_readout and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module oar_readout_props #(
  parameter int CONV_CYCLES = 18
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Straps and link
  input wire logic data_rate_select,
  input wire logic [1:0] io_mode_select,
  input wire logic convert_strobe_n,
  input wire logic echo_clock_out,
  // Status and enables
  input wire logic serial_out_en,
  input wire logic diff_lane_en,
  input wire logic converting,
  input wire logic result_ready,
  input wire oar_pkg::oar_mode_t active_mode,
  // Lane pins
  input wire logic [3:0] lane_p,
  input wire logic [3:0] lane_n
);
  localparam int RDY_LO = CONV_CYCLES - 2;
  localparam int RDY_HI = CONV_CYCLES + 1;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_conv_start: assert property ($fell(convert_strobe_n) |-> ##[2:5] converting)
    else $error("Conversion did not start after strobe fall.");
  chk_ready_time: assert property (disable iff (!resetn || convert_strobe_n)
    $rose(converting) |-> !result_ready ##[RDY_LO:RDY_HI] result_ready)
    else $error("Result ready came at the wrong time.");
  chk_ready_ends_conv: assert property ($rose(result_ready) |-> $fell(converting))
    else $error("Result ready rose while conversion ran on.");
  chk_acquire_idle: assert property (convert_strobe_n [*8] |-> !converting && !result_ready
    && !serial_out_en && !diff_lane_en)
    else $error("Block left acquisition while strobe high.");
  chk_echo_idle: assert property (convert_strobe_n [*2] |-> !echo_clock_out)
    else $error("Echo clock moved while strobe high.");
  chk_mode_latch: assert property ($rose(converting) |-> active_mode ==
    {data_rate_select, io_mode_select != 2'h0, io_mode_select == 2'h2})
    else $error("Latched mode does not match straps.");
  chk_cmos_enable: assert property (result_ready && !active_mode.lvds |-> serial_out_en && !diff_lane_en)
    else $error("Single-ended outputs not enabled alone.");
  chk_lane_enable: assert property (result_ready && active_mode.lvds |-> diff_lane_en && !serial_out_en)
    else $error("Lane outputs not enabled alone.");
  chk_lane_pair: assert property (lane_n == ~lane_p)
    else $error("Lane complement pin does not mirror its true pin.");

  cov_cmos: cover property ($rose(result_ready) && !active_mode.lvds);
  cov_lvds: cover property ($rose(result_ready) && active_mode.lvds);
  cov_ddr: cover property ($rose(result_ready) && active_mode.ddr);
  cov_abort: cover property ($fell(converting) && !result_ready);
endmodule : oar_readout_props

bind oar_readout oar_readout_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .clock(clock), .resetn(resetn), .data_rate_select(data_rate_select),
  .io_mode_select(io_mode_select), .convert_strobe_n(convert_strobe_n),
  .echo_clock_out(echo_clock_out), .serial_out_en(serial_out_en),
  .diff_lane_en(diff_lane_en), .converting(converting),
  .result_ready(result_ready), .active_mode(active_mode),
  .lane_p({diff_lane_d_p, diff_lane_c_p, diff_lane_b_p, diff_lane_a_p}),
  .lane_n({diff_lane_d_n, diff_lane_c_n, diff_lane_b_n, diff_lane_a_n})
);
`default_nettype wire

/* File: bench/oar_host_model.sv */
// Host model: drives convert strobe and shift clock, captures the data lines.
// Assumes data_in carries the eight outputs or the four lanes of the block.
`timescale 1ns/10ps
`default_nettype none

module oar_host_model #(
  parameter real HALF = 62.5
) (
  // Link drive
  output logic shift_clock,
  output logic convert_strobe_n,
  // Device answers
  input wire logic echo_clock_out,
  input wire logic [7:0] data_in,
  input wire logic ready
);
  logic [255:0] cap [8];
  logic ready_seen;
  int echo_bad;

  // A power-up pulse clears the link flops, whose only reset is the strobe.
  initial begin
    shift_clock = 1'b0;
    convert_strobe_n = 1'b0;
    ready_seen = 1'b0;
    echo_bad = 0;
    #1;
    convert_strobe_n = 1'b1;
  end

  task automatic abort_frame(input real low_ns);
    convert_strobe_n = 1'b0;
    #(low_ns);
    ready_seen = ready;
    convert_strobe_n = 1'b1;
    #(HALF * 2);
  endtask : abort_frame

  task automatic frame(input int edges, input logic ddr);
    int k;
    int n;
    n = 0;
    foreach (cap[i]) cap[i] = '0;
    convert_strobe_n = 1'b0;
    for (k = 0; k < 200 && ready !== 1'b1; k++) #5;
    ready_seen = ready;
    while (n < edges) begin
      #(HALF - 12.5);
      if (echo_clock_out !== shift_clock) echo_bad++;
      if (ddr || shift_clock) begin
        foreach (cap[i]) cap[i] = {cap[i][254:0], data_in[i]};
        n++;
      end
      #12.5;
      shift_clock = ~shift_clock;
    end
    #(HALF);
    convert_strobe_n = 1'b1;
    #(HALF * 2);
  endtask : frame
endmodule : oar_host_model
`default_nettype wire

/* File: bench/test_oar_readout.sv */
// Self-checking bench for the convert-and-readout block.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module test_oar_readout;
  logic clock = 1'b0;
  logic resetn;
  logic ddr;
  logic [1:0] io;
  oar_pkg::oar_samples_t smp;
  logic sck, cnv_n, echo, rdy;
  logic [7:0] so;
  logic [3:0] lp;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  oar_readout u_dut (
    .clock(clock), .resetn(resetn), .sample_in(smp), .data_rate_select(ddr),
    .io_mode_select(io), .shift_clock(sck), .convert_strobe_n(cnv_n), .echo_clock_out(echo),
    .serial_out_ch1(so[0]), .serial_out_ch2(so[1]), .serial_out_ch3(so[2]), .serial_out_ch4(so[3]),
    .serial_out_ch5(so[4]), .serial_out_ch6(so[5]), .serial_out_ch7(so[6]), .serial_out_ch8(so[7]),
    .serial_out_en(), .diff_lane_a_p(lp[0]), .diff_lane_a_n(), .diff_lane_b_p(lp[1]), .diff_lane_b_n(),
    .diff_lane_c_p(lp[2]), .diff_lane_c_n(), .diff_lane_d_p(lp[3]), .diff_lane_d_n(), .diff_lane_en(),
    .converting(), .result_ready(rdy), .active_mode()
  );

  oar_host_model u_host (
    .shift_clock(sck), .convert_strobe_n(cnv_n), .echo_clock_out(echo),
    .data_in(io == 2'h0 ? so : {4'h0, lp}), .ready(rdy)
  );

  initial begin
    forever #12.5 clock = ~clock;
  end

  // A frame needs under 1000 cycles, so the ceiling leaves wide margin.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic run_frame(input logic dr, input logic [1:0] im, input int edges, input logic [2:0] f);
    logic [255:0] e;
    logic b;
    @(posedge clock);
    #1;
    ddr = dr;
    io = im;
    for (int c = 0; c < 8; c++) smp.ch[c] = {~f[0], f[1:0], 3'(c), 7'h2B};
    repeat (4) @(posedge clock);
    #1;
    u_host.frame(edges, dr);
    `CHK("result ready", 1'b1, u_host.ready_seen)
    `CHK("echo mismatches", 0, u_host.echo_bad)
    for (int i = 0; i < (im == 2'h0 ? 8 : 4); i++) begin
      e = '0;
      for (int k = 0; k < edges; k++) begin
        if (im == 2'h0) b = smp.ch[(i + k / 13) % 8][12 - k % 13];
        else b = (k % 16 < 13) ? smp.ch[(2 * i + k / 16) % 8][12 - k % 16] : 1'b0;
        e = {e[254:0], b};
      end
      if (im == 2'h0) `CHK("cmos stream", e, u_host.cap[i])
      else `CHK("lane stream", e, u_host.cap[i])
    end
  endtask : run_frame

  initial begin
    resetn = 1'b0;
    ddr = 1'b0;
    io = 2'h0;
    smp = '0;
    repeat (3) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clock);
    run_frame(1'b0, 2'h0, 117, 3'h0);
    run_frame(1'b1, 2'h0, 26, 3'h1);
    run_frame(1'b0, 2'h1, 144, 3'h2);
    run_frame(1'b1, 2'h2, 32, 3'h3);
    run_frame(1'b1, 2'h3, 130, 3'h4);
    @(posedge clock);
    #1;
    u_host.abort_frame(200.0);
    `CHK("aborted ready", 1'b0, u_host.ready_seen)
    run_frame(1'b0, 2'h0, 13, 3'h5);
    close_out();
  end
endmodule : test_oar_readout
`default_nettype wire
